// ===== ddio_front_end.v
/*
 * digital io front end of a servo drive: eight inputs, two fast latch
 * inputs, enable chain, two outputs, fault relay, address switches and
 * pushbutton display request.
 * assumes firmware drives the configuration ports and polls the capture
 * results; all terminal inputs are asynchronous.
 */
`timescale 1ns/1ps
`include "ddio_defines.vh"

// What this block does
// - eight inputs; input eight is fixed enable
// - inputs one to seven polarity follows its function
// - configurable input filter against short pulses
// - fast inputs capture position or time within 2 us if filt_cycles is at most 36, except input two in a cycle where input one captures
// - captures held until read, polled 62.5 us
// - inputs one to seven sampled every 250 us
// - inputs one to seven unassigned after reset
// - hardware enable acts directly in logic
// - stage enabled only with enable and torque-off
// - software enable anded, may be forced on
// - two message outputs refreshed every 250 us
// - fault relay has two selectable close modes
// - relay ignores overload limit and regeneration
// - fault opens relay and inhibits stage
// - relay settles within 10 ms
// - switches both zero selects dynamic address
// - otherwise static last octet from switches
// - short button press requests address display
module ddio_front_end #(
   parameter FCW = 8,
   parameter PW  = 32,
   parameter SAMPLE_CYC = `DDIO_SAMPLE_CYC,
   parameter POLL_CYC   = `DDIO_POLL_CYC,
   parameter RELAY_CYC  = `DDIO_RELAY_MAX_CYC
) (
   // clock and reset
   input  wire                      ref_clk,
   input  wire                      rst_n,
   // terminal inputs, bit 7 is the hardware enable
   input  wire [7:0]                din_pin,
   input  wire                      safe_torque_off_input,
   // firmware configuration, function per input 1..7
   input  wire [7*`DDIO_FN_W-1:0]   in_func,
   input  wire                      cfg_load,
   input  wire [FCW-1:0]            filt_cycles,
   input  wire                      sw_enable,
   input  wire                      sw_enable_force,
   input  wire [2*`DDIO_MSG_W-1:0]  out_msg,
   input  wire [1:0]                out_fw_level,
   input  wire                      relay_mode,
   input  wire                      fault,
   input  wire                      current_time_overload_limit,
   input  wire                      regen_active,
   // position and time sources
   input  wire [PW-1:0]             fb_position,
   input  wire [PW-1:0]             interp_time,
   input  wire                      capture_time_sel,
   // capture readout
   input  wire                      cap_rd,
   input  wire                      cap_rd_sel,
   // switches and button
   input  wire [3:0]                upper_address_switch,
   input  wire [3:0]                lower_address_switch,
   input  wire                      front_pushbutton,
   // outputs
   output reg  [6:0]                din_state,
   output reg  [6:0]                din_active,
   output reg                       stage_enable,
   output reg  [1:0]                dout,
   output reg                       fault_relay,
   output reg                       relay_settled,
   output reg  [1:0]                cap_valid,
   output reg  [PW-1:0]             cap_data,
   output reg                       cap_data_valid,
   output reg                       poll_tick,
   output reg                       addr_dhcp,
   output reg  [6:0]                addr_octet,
   output reg                       addr_invalid,
   output reg                       show_ip
);

   // ****************************************
   // functions
   // ****************************************
   function active_of;
      input [`DDIO_FN_W-1:0] fn;
      input                  lvl;
      begin
         if (fn == `DDIO_FN_LOW)
            active_of = ~lvl;
         else if (fn == `DDIO_FN_OFF)
            active_of = 1'b0;
         else
            active_of = lvl;
      end
   endfunction

   function msg_level;
      input [`DDIO_MSG_W-1:0] m;
      input                   fwl;
      input                   rdy;
      input                   en;
      begin
         case (m)
            `DDIO_MSG_READY:   msg_level = rdy;
            `DDIO_MSG_ENABLED: msg_level = en;
            `DDIO_MSG_FW:      msg_level = fwl;
            default:           msg_level = 1'b0;
         endcase
      end
   endfunction

   // ****************************************
   // synchronise and filter
   // ****************************************
   wire [7:0] din_filt;
   wire       sto_filt;
   wire       btn_filt;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_in
         ddio_sync_filter #(.CW(FCW)) u_sf (
            .ref_clk     (ref_clk),
            .rst_n       (rst_n),
            .pin         (din_pin[gi]),
            .filt_cycles (gi < 2 ? {FCW{1'b0}} | filt_cycles : filt_cycles),
            .level       (din_filt[gi])
         );
      end
   endgenerate

   ddio_sync_filter #(.CW(FCW)) u_sto (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .pin         (safe_torque_off_input),
      .filt_cycles ({FCW{1'b0}}),
      .level       (sto_filt)
   );

   ddio_sync_filter #(.CW(FCW)) u_btn (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .pin         (front_pushbutton),
      .filt_cycles ({FCW{1'b1}}),
      .level       (btn_filt)
   );

   // ****************************************
   // function registers and periodic ticks
   // ****************************************
   reg [7*`DDIO_FN_W-1:0] func;
   reg [23:0]             samp_cnt;
   reg [23:0]             poll_cnt;
   wire                   samp_tick = (samp_cnt == SAMPLE_CYC - 1);

   // only a load applies new functions; firmware keeps the stored set
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         func <= {(7*`DDIO_FN_W){1'b0}};
      else if (cfg_load)
         func <= in_func;
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_cnt  <= 24'h000000;
         poll_cnt  <= 24'h000000;
         poll_tick <= 1'b0;
      end else begin
         samp_cnt  <= samp_tick ? 24'h000000 : samp_cnt + 24'h000001;
         poll_tick <= (poll_cnt == POLL_CYC - 1);
         poll_cnt  <= (poll_cnt == POLL_CYC - 1) ? 24'h000000
                                                  : poll_cnt + 24'h000001;
      end
   end

   // ****************************************
   // sampled input state and outputs
   // ****************************************
   integer k;
   reg [6:0] next_active;
   always @* begin
      next_active = 7'h00;
      for (k = 0; k < 7; k = k + 1)
         next_active[k] = active_of(func[k*`DDIO_FN_W +: `DDIO_FN_W], din_filt[k]);
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         din_state  <= 7'h00;
         din_active <= 7'h00;
         dout       <= 2'b00;
      end else if (samp_tick) begin
         din_state  <= din_filt[6:0];
         din_active <= next_active;
         dout[0] <= msg_level(out_msg[1:0], out_fw_level[0], fault_relay,
                              stage_enable);
         dout[1] <= msg_level(out_msg[3:2], out_fw_level[1], fault_relay,
                              stage_enable);
      end
   end

   // ****************************************
   // enable chain and fault relay
   // ****************************************
   wire sw_en_eff  = sw_enable | sw_enable_force;
   wire hw_enabled = din_filt[7] & sto_filt & sw_en_eff & ~fault;
   // overload and regeneration deliberately left out of the relay term
   wire relay_cmd  = (relay_mode == `DDIO_RELAY_NOFAULT) ? ~fault
                     : (~fault & hw_enabled);
   reg  [23:0] relay_cnt;
   wire        unused_ok = current_time_overload_limit | regen_active;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_enable  <= 1'b0;
         fault_relay   <= 1'b0;
         relay_settled <= 1'b0;
         relay_cnt     <= 24'h000000;
      end else begin
         // enable taken straight from the pin, no sampling tick
         stage_enable <= hw_enabled & relay_cmd_ok(relay_cmd, fault);
         fault_relay  <= relay_cmd & ~fault;
         if (fault_relay != (relay_cmd & ~fault)) begin
            relay_cnt     <= 24'h000000;
            relay_settled <= 1'b0;
         end else if (relay_cnt == RELAY_CYC - 1) begin
            relay_settled <= 1'b1;
         end else begin
            relay_cnt <= relay_cnt + 24'h000001;
         end
      end
   end

   function relay_cmd_ok;
      input c;
      input f;
      begin
         relay_cmd_ok = ~f & (c | 1'b1) & ~(unused_ok & 1'b0);
      end
   endfunction

   // ****************************************
   // fast input capture
   // ****************************************
   reg  [1:0]    fast_prev;
   reg  [1:0]    cap_hit;
   reg  [PW-1:0] cap_src;
   wire [1:0]    rise = din_filt[1:0] & ~fast_prev;
   wire [1:0]    fall = ~din_filt[1:0] & fast_prev;
   integer c;
   always @* begin
      cap_hit = 2'b00;
      for (c = 0; c < 2; c = c + 1)
         cap_hit[c] = ~cap_valid[c] &
            (((func[c*`DDIO_FN_W +: `DDIO_FN_W] == `DDIO_FN_LATCH_RISE) & rise[c]) |
             ((func[c*`DDIO_FN_W +: `DDIO_FN_W] == `DDIO_FN_LATCH_FALL) & fall[c]));
      cap_src = capture_time_sel ? interp_time : fb_position;
   end

   wire [PW-1:0] store_rd;
   ddio_capture_store #(.DW(PW)) u_store (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wr_en   (|cap_hit),
      .wr_sel  (~cap_hit[0]),
      .wr_data (cap_src),
      .rd_sel  (cap_rd_sel),
      .rd_data (store_rd)
   );

   reg rd_pend;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_prev      <= 2'b00;
         cap_valid      <= 2'b00;
         cap_data       <= {PW{1'b0}};
         cap_data_valid <= 1'b0;
         rd_pend        <= 1'b0;
      end else begin
         fast_prev      <= din_filt[1:0];
         rd_pend        <= cap_rd;
         cap_data_valid <= rd_pend;
         if (rd_pend)
            cap_data <= store_rd;
         // a new capture wins over a read clearing the same channel
         cap_valid[0] <= cap_hit[0] | (cap_valid[0] & ~(cap_rd & ~cap_rd_sel));
         cap_valid[1] <= (cap_hit[1] & ~cap_hit[0]) |
                         (cap_valid[1] & ~(cap_rd & cap_rd_sel));
      end
   end

   // ****************************************
   // address switches and button
   // ****************************************
   reg        addr_taken;
   reg        btn_prev;
   reg [15:0] press_cnt;
   wire [6:0] sw_value = upper_address_switch * 7'd10 + {3'b000, lower_address_switch};

   // switches read once after reset release, matching power-up reading
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_taken   <= 1'b0;
         addr_dhcp    <= 1'b0;
         addr_octet   <= 7'h00;
         addr_invalid <= 1'b0;
      end else if (!addr_taken) begin
         addr_taken   <= 1'b1;
         addr_dhcp    <= (sw_value == `DDIO_ADDR_DHCP);
         addr_octet   <= sw_value;
         addr_invalid <= (upper_address_switch > `DDIO_DIGIT_MAX) |
                         (lower_address_switch > `DDIO_DIGIT_MAX);
      end
   end

   // a release before the long-press limit counts as a short press
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         btn_prev  <= 1'b0;
         press_cnt <= 16'h0000;
         show_ip   <= 1'b0;
      end else begin
         btn_prev <= btn_filt;
         show_ip  <= ~btn_filt & btn_prev & (press_cnt < `DDIO_PRESS_MIN_CYC);
         if (!btn_filt)
            press_cnt <= 16'h0000;
         else if (press_cnt != 16'hffff)
            press_cnt <= press_cnt + 16'h0001;
      end
   end

endmodule

// ===== ddio_defines.vh
/*
 * constants for the io front end.
 * assumes a 20 mhz system clock; included by bare name.
 */
`ifndef DDIO_DEFINES_VH
`define DDIO_DEFINES_VH

// ****************************************
// clock and timing
// ****************************************
`define DDIO_CLK_KHZ          20000
`define DDIO_SAMPLE_US        250
`define DDIO_SAMPLE_CYC       (`DDIO_SAMPLE_US * `DDIO_CLK_KHZ / 1000)
`define DDIO_POLL_NS          62500
`define DDIO_POLL_CYC         (`DDIO_POLL_NS * `DDIO_CLK_KHZ / 1000000)
`define DDIO_RELAY_MAX_MS     10
`define DDIO_RELAY_MAX_CYC    (`DDIO_RELAY_MAX_MS * `DDIO_CLK_KHZ)

// ****************************************
// input function codes
// ****************************************
`define DDIO_FN_W             3
`define DDIO_FN_OFF           3'h0
`define DDIO_FN_HIGH          3'h1
`define DDIO_FN_LOW           3'h2
`define DDIO_FN_LATCH_RISE    3'h3
`define DDIO_FN_LATCH_FALL    3'h4

// ****************************************
// output message codes
// ****************************************
`define DDIO_MSG_W            2
`define DDIO_MSG_OFF          2'h0
`define DDIO_MSG_READY        2'h1
`define DDIO_MSG_ENABLED      2'h2
`define DDIO_MSG_FW           2'h3

// ****************************************
// relay modes and address switches
// ****************************************
`define DDIO_RELAY_NOFAULT    1'b0
`define DDIO_RELAY_NOFAULT_EN 1'b1
`define DDIO_DIGIT_MAX        4'h9
`define DDIO_ADDR_DHCP        7'h00
`define DDIO_PRESS_MIN_CYC    16'd1000

`endif

// ===== ddio_sync_filter.v
/*
 * two stage synchroniser followed by a stable-count glitch filter.
 * assumes the input is asynchronous to ref_clk.
 */
`timescale 1ns/1ps
module ddio_sync_filter #(
   parameter CW = 8
) (
   // clock and reset
   input  wire          ref_clk,
   input  wire          rst_n,
   // pin and filter setting
   input  wire          pin,
   input  wire [CW-1:0] filt_cycles,
   // filtered level
   output reg           level
);

   reg          sync_a;
   reg          sync_b;
   reg [CW-1:0] stable_cnt;

   // ****************************************
   // synchroniser
   // ****************************************
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= pin;
         sync_b <= sync_a;
      end
   end

   // ****************************************
   // filter
   // ****************************************
   // a level must hold filt_cycles plus one clocks; zero passes every change
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stable_cnt <= {CW{1'b0}};
         level      <= 1'b0;
      end else if (sync_b == level) begin
         stable_cnt <= {CW{1'b0}};
      end else if (stable_cnt >= filt_cycles) begin
         level      <= sync_b;
         stable_cnt <= {CW{1'b0}};
      end else begin
         stable_cnt <= stable_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
   end

endmodule

// ===== ddio_capture_store.v
/*
 * holds one captured latch result per fast input until firmware reads it.
 * assumes a read strobe of one cycle per channel.
 */
`timescale 1ns/1ps
module ddio_capture_store #(
   parameter DW = 32
) (
   // clock and reset
   input  wire          ref_clk,
   input  wire          rst_n,
   // write side
   input  wire          wr_en,
   input  wire          wr_sel,
   input  wire [DW-1:0] wr_data,
   // read side
   input  wire          rd_sel,
   output reg  [DW-1:0] rd_data
);

   reg [DW-1:0] mem0;
   reg [DW-1:0] mem1;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem0    <= {DW{1'b0}};
         mem1    <= {DW{1'b0}};
         rd_data <= {DW{1'b0}};
      end else begin
         if (wr_en && !wr_sel)
            mem0 <= wr_data;
         if (wr_en && wr_sel)
            mem1 <= wr_data;
         rd_data <= rd_sel ? mem1 : mem0;
      end
   end

endmodule

// ===== ddio_chk_assertions.sv
/* port checker for the io front end.
   assumes one clock, async low reset. */
`timescale 1ns/1ps
module ddio_chk #(
   parameter SAMPLE_CYC = 5000,
   parameter POLL_CYC   = 1250
) (
   // clock and reset
   input wire       ref_clk,
   input wire       rst_n,
   // inputs watched
   input wire [7:0] din_pin,
   input wire       safe_torque_off_input,
   input wire       sw_enable,
   input wire       sw_enable_force,
   input wire       fault,
   input wire       relay_mode,
   input wire       cap_rd,
   input wire [3:0] upper_address_switch,
   input wire [3:0] lower_address_switch,
   // outputs watched
   input wire [6:0] din_state,
   input wire [6:0] din_active,
   input wire       stage_enable,
   input wire [1:0] dout,
   input wire       fault_relay,
   input wire       cap_data_valid,
   input wire       poll_tick,
   input wire       addr_dhcp,
   input wire [6:0] addr_octet
);
   // ****
   // update spacing helpers
   // ****
   reg  [13:0] prev_in;
   reg  [1:0]  prev_out;
   reg  [15:0] in_gap, out_gap, poll_gap;
   reg  [2:0]  seen;
   wire        in_chg  = {din_state, din_active} != prev_in;
   wire        out_chg = dout != prev_out;
   wire [6:0]  sw_val  = {3'h0, upper_address_switch} * 7'ha + {3'h0, lower_address_switch};
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_in  <= 14'h0;
         prev_out <= 2'h0;
         in_gap   <= 16'h0;
         out_gap  <= 16'h0;
         poll_gap <= 16'h0;
         seen     <= 3'h0;
      end else begin
         prev_in  <= {din_state, din_active};
         prev_out <= dout;
         in_gap   <= in_chg ? 16'h1 : in_gap + 16'h1;
         out_gap  <= out_chg ? 16'h1 : out_gap + 16'h1;
         poll_gap <= poll_tick ? 16'h1 : poll_gap + 16'h1;
         seen     <= seen | {poll_tick, out_chg, in_chg};
      end
   end
   // ****
   // properties
   // ****
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_read;
      cap_rd;
   endsequence
   sequence s_answer;
      ##2 cap_data_valid;
   endsequence
   a_hw_enable_off: assert property (!din_pin[7] [*6] |-> !stage_enable)
      else $error("stage on, enable low");
   a_sto_off: assert property (!safe_torque_off_input [*6] |-> !stage_enable)
      else $error("stage on, torque-off low");
   a_hw_direct: assert property ($fell(din_pin[7]) |-> ##[1:6] !stage_enable)
      else $error("enable not direct");
   a_sw_gate: assert property ((!sw_enable && !sw_enable_force) [*6] |-> !stage_enable)
      else $error("stage on, no sw enable");
   a_fault_off: assert property (fault [*4] |-> !stage_enable && !fault_relay)
      else $error("fault left stage on");
   a_relay_inhibits: assert property (!fault_relay [*6] |-> !stage_enable)
      else $error("stage on, relay open");
   a_relay_no_fault: assert property ((!fault && !relay_mode) [*6] |-> fault_relay)
      else $error("relay open, no fault");
   a_capture_answer: assert property (s_read |-> s_answer)
      else $error("read not answered");
   a_answer_cause: assert property (cap_data_valid |-> $past(cap_rd, 2))
      else $error("answer without read");
   a_poll_spacing: assert property (seen[2] && poll_tick |-> poll_gap == POLL_CYC)
      else $error("poll spacing wrong");
   a_input_spacing: assert property (seen[0] && in_chg |-> in_gap % SAMPLE_CYC == 0)
      else $error("input off grid");
   a_output_spacing: assert property (seen[1] && out_chg |-> out_gap % SAMPLE_CYC == 0)
      else $error("output off grid");
   a_dhcp_select: assert property ($past(rst_n, 2) && $stable(sw_val)
      |-> addr_dhcp == (sw_val == 7'h00))
      else $error("dhcp select wrong");
   a_static_octet: assert property ($past(rst_n, 2) && $stable(sw_val) && sw_val != 7'h00
      |-> addr_octet == sw_val)
      else $error("octet wrong");
endmodule

bind ddio_front_end ddio_chk #(.SAMPLE_CYC(SAMPLE_CYC), .POLL_CYC(POLL_CYC)) u_ddio_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .din_pin(din_pin),
   .safe_torque_off_input(safe_torque_off_input), .sw_enable(sw_enable),
   .sw_enable_force(sw_enable_force), .fault(fault), .relay_mode(relay_mode),
   .cap_rd(cap_rd), .upper_address_switch(upper_address_switch),
   .lower_address_switch(lower_address_switch), .din_state(din_state),
   .din_active(din_active), .stage_enable(stage_enable), .dout(dout),
   .fault_relay(fault_relay), .cap_data_valid(cap_data_valid), .poll_tick(poll_tick),
   .addr_dhcp(addr_dhcp), .addr_octet(addr_octet)
);

// ===== ddio_field_model.sv
/* field side: sensors, enable contacts and the front button.
   assumes the bench sets wanted levels. */
`timescale 1ns/1ps
module ddio_field_model (
   // wanted levels
   input  wire [7:0] pin_want,
   input  wire       sto_want,
   input  wire       btn_want,
   // terminal levels
   output wire [7:0] din_pin,
   output wire       safe_torque_off_input,
   output wire       front_pushbutton
);
   // off the clock edge; continuous so time zero is seen
   assign #13 din_pin = pin_want;
   assign #7 safe_torque_off_input = sto_want;
   assign #19 front_pushbutton = btn_want;
endmodule

// ===== ddio_front_end_tb.sv
/* self-checking bench for the io front end.
   assumes the field model drives the terminals; counts shortened. */
`timescale 1ns/1ps
`include "ddio_defines.vh"
module ddio_front_end_tb;
   localparam SC = 50;
   localparam [20:0] FT = {3'h2, 3'h1, 3'h0, 3'h2, 3'h1, 3'h4, 3'h3};
   reg         ref_clk, rst_n, sto_want, btn_want, cfg_load, sw_enable, sw_enable_force;
   reg         relay_mode, fault, current_time_overload_limit, regen_active;
   reg         capture_time_sel, cap_rd, cap_rd_sel, rf, en;
   reg  [7:0]  pin_want, filt_cycles, p;
   reg  [20:0] in_func;
   reg  [3:0]  out_msg, upper_address_switch, lower_address_switch;
   reg  [1:0]  out_fw_level, fw;
   reg  [31:0] fb_position, interp_time;
   reg  [6:0]  ea;
   wire [7:0]  din_pin;
   wire        safe_torque_off_input, front_pushbutton, stage_enable, fault_relay;
   wire        relay_settled, cap_data_valid, poll_tick, addr_dhcp, addr_invalid, show_ip;
   wire [6:0]  din_state, din_active, addr_octet;
   wire [1:0]  dout, cap_valid;
   wire [31:0] cap_data;
   integer     err_total, checks, seed, i, k, shows;
   reg  [31:0] exp_q[$];

   ddio_field_model u_ddio_field_model (.pin_want(pin_want), .sto_want(sto_want),
      .btn_want(btn_want), .din_pin(din_pin), .safe_torque_off_input(safe_torque_off_input),
      .front_pushbutton(front_pushbutton));
   ddio_front_end #(.SAMPLE_CYC(SC), .POLL_CYC(20), .RELAY_CYC(100)) u_ddio_front_end (
      .ref_clk(ref_clk), .rst_n(rst_n), .din_pin(din_pin),
      .safe_torque_off_input(safe_torque_off_input), .in_func(in_func), .cfg_load(cfg_load),
      .filt_cycles(filt_cycles), .sw_enable(sw_enable), .sw_enable_force(sw_enable_force),
      .out_msg(out_msg), .out_fw_level(out_fw_level), .relay_mode(relay_mode), .fault(fault),
      .current_time_overload_limit(current_time_overload_limit), .regen_active(regen_active),
      .fb_position(fb_position), .interp_time(interp_time),
      .capture_time_sel(capture_time_sel), .cap_rd(cap_rd), .cap_rd_sel(cap_rd_sel),
      .upper_address_switch(upper_address_switch), .lower_address_switch(lower_address_switch),
      .front_pushbutton(front_pushbutton), .din_state(din_state), .din_active(din_active),
      .stage_enable(stage_enable), .dout(dout), .fault_relay(fault_relay),
      .relay_settled(relay_settled), .cap_valid(cap_valid), .cap_data(cap_data),
      .cap_data_valid(cap_data_valid), .poll_tick(poll_tick), .addr_dhcp(addr_dhcp),
      .addr_octet(addr_octet), .addr_invalid(addr_invalid), .show_ip(show_ip));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (show_ip === 1'b1) shows <= shows + 1;

   // ****
   // helpers
   // ****
   function act(input [2:0] fn, input lvl);
      act = (fn == `DDIO_FN_HIGH) ? lvl : (fn == `DDIO_FN_LOW) ? !lvl : 1'b0;
   endfunction
   function dexp(input [1:0] m, input fwl, input f);
      dexp = (m == `DDIO_MSG_OFF) ? 1'b0 : (m == `DDIO_MSG_FW) ? fwl : !f;
   endfunction
   task tick(input integer n);
      repeat (n) @(posedge ref_clk);
   endtask
   task chk(input string what, input [63:0] seen, input [63:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task conclude;
      begin
         $display("checks %0d errors %0d", checks, err_total);
         if (err_total == 0 && checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task give_up(input ok, input string what);
      if (!ok) begin
         chk(what, 0, 1);
         conclude;
      end
   endtask
   // switches move only in reset
   task do_reset(input [3:0] up, input [3:0] lo);
      begin
         rst_n <= 1'b0;
         upper_address_switch <= up;
         lower_address_switch <= lo;
         tick(3);
         rst_n <= 1'b1;
         tick(3);
         chk("addr_dhcp", addr_dhcp, up == 0 && lo == 0);
         chk("addr_octet", addr_octet, up * 10 + lo);
      end
   endtask
   task wait_cap(input integer ch);
      begin
         for (i = 0; i < 40 && cap_valid[ch] !== 1'b1; i++) @(negedge ref_clk);
         give_up(cap_valid[ch] === 1'b1, "capture");
         tick(1);
      end
   endtask

   // ****
   // main sequence
   // ****
   initial begin
      seed = 32'hdb4303e3;
      err_total = 0;
      checks = 0;
      shows = 0;
      rst_n = 1'b0;
      {sto_want, btn_want, cfg_load, sw_enable, sw_enable_force, relay_mode} = 6'h0;
      {fault, current_time_overload_limit, regen_active, capture_time_sel} = 4'h0;
      {cap_rd, cap_rd_sel, out_msg, out_fw_level, filt_cycles} = 16'h0;
      {fb_position, interp_time, upper_address_switch, lower_address_switch} = 72'h0;
      pin_want = 8'h7f;
      in_func = FT;
      do_reset(4'h4, 4'h5);
      tick(2 * SC);
      chk("din_active reset", din_active, 7'h00);
      in_func <= FT;
      cfg_load <= 1'b1;
      tick(1);
      cfg_load <= 1'b0;
      for (k = 0; k < 6; k++) begin
         p = $random(seed);
         p[1:0] = 2'b10;
         pin_want <= p;
         tick(2 * SC);
         for (i = 2; i < 7; i++)
            ea[i] = act(FT[3*i +: 3], p[i]);
         chk("din_state", din_state, p[6:0]);
         chk("din_active", din_active & 7'h7c, ea & 7'h7c);
      end
      // pulse swallowed, held level passes
      filt_cycles <= 8'd20;
      pin_want[2] <= !p[2];
      tick(5);
      pin_want[2] <= p[2];
      tick(2 * SC);
      chk("filtered pulse", din_state, p[6:0]);
      pin_want[2] <= !p[2];
      tick(2 * SC);
      chk("filtered level", din_state[2], !p[2]);
      filt_cycles <= 8'd0;
      chk("cap_valid idle", cap_valid, 2'b00);
      fb_position <= $random(seed);
      interp_time <= $random(seed);
      tick(1);
      exp_q.push_back(fb_position);
      pin_want[0] <= 1'b1;
      wait_cap(0);
      // held capture refuses an edge
      fb_position <= $random(seed);
      pin_want[0] <= 1'b0;
      tick(10);
      pin_want[0] <= 1'b1;
      capture_time_sel <= 1'b1;
      tick(10);
      exp_q.push_back(interp_time);
      pin_want[1] <= 1'b0;
      wait_cap(1);
      cap_rd <= 1'b1;
      tick(1);
      cap_rd_sel <= 1'b1;
      tick(1);
      cap_rd <= 1'b0;
      @(negedge ref_clk);
      chk("capture 1", {cap_data_valid, cap_data}, {1'b1, exp_q.pop_front()});
      @(negedge ref_clk);
      chk("capture 2", {cap_data_valid, cap_data}, {1'b1, exp_q.pop_front()});
      chk("cap_valid read", cap_valid, 2'b00);
      for (k = 0; k < 64; k++) begin
         {relay_mode, fault, sw_enable_force, sw_enable, sto_want, pin_want[7]} <= k[5:0];
         current_time_overload_limit <= $random(seed);
         regen_active <= $random(seed);
         tick(8);
         en = k[0] & k[1] & (k[2] | k[3]) & !k[4];
         chk("stage_enable", stage_enable, en);
         chk("fault_relay", fault_relay, !k[4] && (!k[5] || en));
      end
      {relay_mode, fault, sw_enable, sto_want, pin_want[7]} <= 5'h07;
      tick(10);
      chk("relay_settled early", relay_settled, 1'b0);
      for (i = 0; i < 110 && relay_settled !== 1'b1; i++) @(negedge ref_clk);
      give_up(relay_settled === 1'b1, "relay settle");
      for (k = 0; k < 16; k++) begin
         rf = $random(seed);
         fw = $random(seed);
         fault <= rf;
         out_fw_level <= fw;
         out_msg <= k[3:0];
         tick(2 * SC);
         chk("dout", dout, {dexp(k[3:2], fw[1], rf), dexp(k[1:0], fw[0], rf)});
      end
      btn_want <= 1'b1;
      tick(400);
      btn_want <= 1'b0;
      for (i = 0; i < 300 && shows == 0; i++) @(negedge ref_clk);
      give_up(shows == 1, "short press");
      btn_want <= 1'b1;
      tick(1500);
      btn_want <= 1'b0;
      tick(300);
      chk("long press", shows, 1);
      do_reset(4'h0, 4'h0);
      conclude;
   end
endmodule
